// ===== hw/wdg_consts.svh
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

// ****************************************
// register addresses and fields
// ****************************************
`define WDG_AUX_CONTROL_ADDR     8'h8e
`define WDG_SERVICE_ADDR         8'ha6
`define WDG_AUX_RESET            8'h00
`define WDG_AUX_RST_OUT_DIS_BIT  3
`define WDG_AUX_IDLE_HOLD_BIT    4
`define WDG_AUX_ALE_DIS_BIT      0
`define WDG_AUX_WRITE_MASK       8'h19

// ****************************************
// service sequence bytes
// ****************************************
`define WDG_ARM_BYTE_FIRST       8'h1e
`define WDG_ARM_BYTE_SECOND      8'he1

// ****************************************
// timing
// ****************************************
`define WDG_COUNT_WIDTH          13
`define WDG_TERMINAL_COUNT       13'h1fff
`define WDG_OSC_PER_MACHINE      4'hc
`define WDG_RST_PULSE_OSC        7'h62

`endif

// ===== hw/wdg_pkg.sv
`include "wdg_consts.svh"

package wdg_pkg;

    // ****************************************
    // special function register write/read port
    // ****************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdg_sfr_req_t;

    typedef enum logic [1:0] {
        WDG_SEQ_IDLE,
        WDG_SEQ_GOT_FIRST
    } wdg_seq_state_t;

    typedef struct packed {
        logic       reset_out;
        logic       device_reset;
        logic       armed;
    } wdg_status_t;

endpackage : wdg_pkg

// ===== hw/wdg_reset_pulse.sv
`include "wdg_consts.svh"

// ****************************************
// reset pin pulse stretcher
// ****************************************
module wdg_reset_pulse (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic start_i,
    input  wire logic drive_en_i,
    output logic      pin_drive_o,
    output logic      pin_oe_n_o,
    output logic      busy_o
);

    typedef struct packed {
        logic [6:0] cnt;
        logic       drive;
        logic       busy;
    } wdg_pulse_state_t;

    wdg_pulse_state_t st_r;
    wdg_pulse_state_t st_nxt;

    // pulse length counted in oscillator periods, one per clk
    always_comb begin
        st_nxt = st_r;
        if (st_r.busy) begin
            if (st_r.cnt == 7'h01) begin
                st_nxt.busy  = 1'b0;
                st_nxt.drive = 1'b0;
                st_nxt.cnt   = 7'h00;
            end else begin
                st_nxt.cnt = st_r.cnt - 7'h01;
            end
        end else if (start_i) begin
            st_nxt.busy  = 1'b1;
            st_nxt.drive = drive_en_i; // R09
            st_nxt.cnt   = `WDG_RST_PULSE_OSC; // R08
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_drive_o = st_r.drive;
    assign pin_oe_n_o  = ~st_r.drive; // low while driving high
    assign busy_o      = st_r.busy;

endmodule : wdg_reset_pulse

// ===== hw/wdg_watchdog.sv
// Overview of operation
// (R01) After any reset the watchdog is off and does not count until armed; a reset from rst_pin_i here leaves it armed and counting.
// (R02) Writing 0x1e then 0xe1 to the service register arms the watchdog.
// (R03) While armed the counter advances once per machine cycle while the oscillator runs.
// (R04) The 13-bit counter overflows at 0x1fff and that overflow resets the whole device. Here the aux control bits keep their values through it.
// (R05) Once armed nothing in software disarms it; only hardware or overflow reset does.
// (R06) Software services often enough and each completed sequence restarts the count at zero.
// (R07) The service register is write-only and the counter is neither readable nor writable.
// (R08) On overflow with reset output allowed the reset pin is driven high for 98 oscillator periods.
// (R09) Reset-out-disable at 0 lets timeout drive the reset pin; at 1 the pin stays input only.
// (R10) Idle-hold at 0 keeps counting in idle; at 1 counting pauses in idle and resumes after.
// (R11) In power-down the counter holds and no timeout is generated.
// (R12) After power-down exit by level interrupt, counting waits until that input goes high.
// (R13) Software should service before power-down and inside the wake-up interrupt handler.
// (R14) When counting in idle, software should wake periodically by timer to service.
// (R15) A 0x1e followed by any other write than 0xe1 is not a sequence; detection restarts. Here writes to other registers between the two bytes are ignored.
`include "wdg_consts.svh"

module wdg_watchdog (
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire wdg_pkg::wdg_sfr_req_t sfr_i,
    output logic [7:0]                sfr_rdata_o,
    output logic                      sfr_hit_o,
    input  wire logic                 idle_i,
    input  wire logic                 power_down_i,
    input  wire logic                 ext_int_n_i,
    input  wire logic                 rst_pin_i,
    output logic                      rst_pin_o,
    output logic                      rst_pin_oe_n_o,
    output logic                      device_reset_o,
    output logic                      ale_disable_o,
    output logic                      armed_o
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] int_sync_r;
    logic [1:0] rst_sync_r;

    // pins arrive asynchronously, two flops before any use
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            int_sync_r <= 2'b11;
            rst_sync_r <= 2'b00;
        end else begin
            int_sync_r <= {int_sync_r[0], ext_int_n_i};
            rst_sync_r <= {rst_sync_r[0], rst_pin_i};
        end
    end

    logic ext_int_n_s;
    logic rst_pin_s;
    assign ext_int_n_s = int_sync_r[1];
    assign rst_pin_s   = rst_sync_r[1];

    // ****************************************
    // block state
    // ****************************************
    typedef struct packed {
        logic                            armed;
        wdg_pkg::wdg_seq_state_t         seq;
        logic [`WDG_COUNT_WIDTH-1:0]     cnt;
        logic [3:0]                      osc_div;
        logic [7:0]                      aux;
        logic                            pd_wait;
        logic                            pd_seen;
        logic                            ovf;
        logic [7:0]                      rdata;
        logic                            hit;
    } wdg_state_t;

    wdg_state_t st_r;
    wdg_state_t st_nxt;

    logic pulse_busy;
    logic pin_drive;
    logic pin_oe_n;

    // decode helpers
    logic wr_service;
    logic wr_aux;
    logic seq_done;
    logic mc_tick;
    logic run_ok;

    assign wr_service = sfr_i.wr && (sfr_i.addr == `WDG_SERVICE_ADDR);
    assign wr_aux     = sfr_i.wr && (sfr_i.addr == `WDG_AUX_CONTROL_ADDR);
    assign seq_done   = wr_service && (st_r.seq == wdg_pkg::WDG_SEQ_GOT_FIRST)
                        && (sfr_i.wdata == `WDG_ARM_BYTE_SECOND); // R02
    assign mc_tick    = (st_r.osc_div == (`WDG_OSC_PER_MACHINE - 4'h1));

    // counting stops for power-down, held idle, or the wake interrupt still low
    // the wait flag lands one cycle after power-down falls, so that cycle is blocked here too
    assign run_ok = st_r.armed && !power_down_i && !st_r.pd_wait // R11 R12
                    && !(st_r.pd_seen && !ext_int_n_s) // R12
                    && !(idle_i && st_r.aux[`WDG_AUX_IDLE_HOLD_BIT]); // R10

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt     = st_r;
        st_nxt.ovf = 1'b0;
        st_nxt.hit = 1'b0;

        // machine cycle divider, frozen with the oscillator in power-down
        if (!power_down_i) begin
            st_nxt.osc_div = mc_tick ? 4'h0 : st_r.osc_div + 4'h1; // R03
        end

        // sequence detector; any wrong byte after the first returns to waiting, except a repeated 0x1e which stays as the first
        if (wr_service) begin
            case (st_r.seq)
                wdg_pkg::WDG_SEQ_IDLE: begin
                    if (sfr_i.wdata == `WDG_ARM_BYTE_FIRST) begin
                        st_nxt.seq = wdg_pkg::WDG_SEQ_GOT_FIRST;
                    end
                end
                wdg_pkg::WDG_SEQ_GOT_FIRST: begin
                    if (sfr_i.wdata == `WDG_ARM_BYTE_FIRST) begin
                        st_nxt.seq = wdg_pkg::WDG_SEQ_GOT_FIRST;
                    end else begin
                        st_nxt.seq = wdg_pkg::WDG_SEQ_IDLE; // R15
                    end
                end
                default: begin
                    st_nxt.seq = wdg_pkg::WDG_SEQ_IDLE;
                end
            endcase
        end

        // arming is sticky; there is no path that clears it in software
        if (seq_done) begin
            st_nxt.armed = 1'b1; // R02 R05
            st_nxt.cnt   = '0; // R06
        end else if (run_ok && mc_tick) begin
            if (st_r.cnt == `WDG_TERMINAL_COUNT) begin
                st_nxt.ovf = 1'b1; // R04
            end else begin
                st_nxt.cnt = st_r.cnt + 13'h0001; // R03
            end
        end

        // power-down exit via interrupt: wait until the line returns high
        st_nxt.pd_seen = power_down_i;
        if (st_r.pd_seen && !power_down_i && !ext_int_n_s) begin
            st_nxt.pd_wait = 1'b1; // R12
        end else if (ext_int_n_s) begin
            st_nxt.pd_wait = 1'b0;
        end

        // aux control: only implemented bits take writes
        if (wr_aux) begin
            st_nxt.aux = sfr_i.wdata & `WDG_AUX_WRITE_MASK;
        end

        // reads: service register returns nothing, counter never visible
        st_nxt.rdata = 8'h00;
        if (sfr_i.rd && sfr_i.addr == `WDG_AUX_CONTROL_ADDR) begin
            st_nxt.rdata = st_r.aux;
            st_nxt.hit   = 1'b1;
        end else if (sfr_i.rd && sfr_i.addr == `WDG_SERVICE_ADDR) begin
            st_nxt.hit = 1'b1; // R07
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // overflow reset clears the block directly from st_r.ovf, keeping the aux bits that only reset_i reloads
    always_ff @(posedge clk_i) begin
        if (reset_i || st_r.ovf) begin
            st_r       <= '0; // R01 R05
            st_r.aux   <= (reset_i) ? `WDG_AUX_RESET : st_r.aux;
            st_r.seq   <= wdg_pkg::WDG_SEQ_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // reset pulse
    // ****************************************
    wdg_reset_pulse u_pulse (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .start_i     (st_r.ovf),
        .drive_en_i  (~st_r.aux[`WDG_AUX_RST_OUT_DIS_BIT]), // R09
        .pin_drive_o (pin_drive),
        .pin_oe_n_o  (pin_oe_n),
        .busy_o      (pulse_busy)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign rst_pin_o      = pin_drive; // R08
    assign rst_pin_oe_n_o = pin_oe_n;
    // internal reset lasts the pulse even when the pin is left as input
    assign device_reset_o = st_r.ovf | pulse_busy | rst_pin_s; // R04
    assign sfr_rdata_o    = st_r.rdata;
    assign sfr_hit_o      = st_r.hit;
    assign ale_disable_o  = st_r.aux[`WDG_AUX_ALE_DIS_BIT];
    assign armed_o        = st_r.armed;

endmodule : wdg_watchdog

// ===== test/wdg_watchdog_chk.sv
`include "wdg_consts.svh"
// ****************************************
// watchdog port checker
// ****************************************
module wdg_watchdog_chk (
    input wire logic                  clk_i,
    input wire logic                  reset_i,
    input wire wdg_pkg::wdg_sfr_req_t sfr_i,
    input wire logic [7:0]            sfr_rdata_o,
    input wire logic                  sfr_hit_o,
    input wire logic                  idle_i,
    input wire logic                  power_down_i,
    input wire logic                  ext_int_n_i,
    input wire logic                  rst_pin_i,
    input wire logic                  rst_pin_o,
    input wire logic                  rst_pin_oe_n_o,
    input wire logic                  device_reset_o,
    input wire logic                  ale_disable_o,
    input wire logic                  armed_o
);
    logic [7:0] aux_r;
    logic [6:0] cnt_r;
    wire        svc_w = sfr_i.wr && sfr_i.addr == 8'ha6;
    // shadow aux bits, length of pin pulse
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            aux_r <= 8'h00;
            cnt_r <= 7'h00;
        end else begin
            if (sfr_i.wr && sfr_i.addr == 8'h8e) aux_r <= sfr_i.wdata & 8'h19;
            cnt_r <= rst_pin_o ? cnt_r + 7'h01 : 7'h00;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_pin_oe_pair: assert property (rst_pin_o != rst_pin_oe_n_o)
        else $error("pin drive and enable disagree");
    chk_reset_idle: assert property ($fell(reset_i) |-> !armed_o && rst_pin_oe_n_o)
        else $error("active after reset");
    chk_arm_seq: assert property (svc_w && sfr_i.wdata == 8'h1e ##1 svc_w && sfr_i.wdata == 8'he1 |=> armed_o)
        else $error("sequence did not arm");
    chk_bad_second: assert property (!armed_o && svc_w && sfr_i.wdata == 8'h1e ##1 svc_w && sfr_i.wdata != 8'he1
        && sfr_i.wdata != 8'h1e ##1 svc_w && sfr_i.wdata == 8'he1 |=> !armed_o)
        else $error("broken sequence armed");
    chk_no_disarm: assert property ($fell(armed_o) |-> device_reset_o || $past(device_reset_o))
        else $error("disarmed without reset");
    chk_svc_read: assert property (sfr_i.rd && sfr_i.addr == 8'ha6 |=> sfr_hit_o && sfr_rdata_o == 8'h00)
        else $error("service read not zero");
    chk_aux_read: assert property (sfr_i.rd && !sfr_i.wr && sfr_i.addr == 8'h8e |=> sfr_rdata_o == aux_r)
        else $error("aux read wrong");
    chk_pulse_start: assert property ($rose(device_reset_o) && $past(armed_o) && !aux_r[3]
        && !$past(rst_pin_i, 2) |=> rst_pin_o)
        else $error("pulse did not start");
    chk_pulse_len: assert property ($fell(rst_pin_o) && !$past(reset_i) |-> cnt_r == 7'h62)
        else $error("pulse length wrong");
    chk_dis_nodrive: assert property (aux_r[3] && $rose(device_reset_o) |=> rst_pin_oe_n_o [*8])
        else $error("pin driven while disabled");
endmodule : wdg_watchdog_chk

bind wdg_watchdog wdg_watchdog_chk i_chk (.clk_i(clk_i), .reset_i(reset_i), .sfr_i(sfr_i),
    .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .idle_i(idle_i), .power_down_i(power_down_i),
    .ext_int_n_i(ext_int_n_i), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o),
    .device_reset_o(device_reset_o), .ale_disable_o(ale_disable_o), .armed_o(armed_o));

// ===== test/tb_top.sv
// ****************************************
// watchdog bench
// ****************************************
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk_i, reset_i, idle_i, power_down_i, ext_int_n_i, rst_pin_i;
    logic                  sfr_hit_o, rst_pin_o, rst_pin_oe_n_o, device_reset_o, ale_disable_o, armed_o;
    logic [7:0]            sfr_rdata_o;
    wdg_pkg::wdg_sfr_req_t sfr;
    int                    n_mismatch, checks_done, cycles, n;
    // pin reset input driven by the bench: an outside reset must not make the block drive the pin
    wdg_watchdog i_dut (.clk_i(clk_i), .reset_i(reset_i), .sfr_i(sfr), .sfr_rdata_o(sfr_rdata_o),
        .sfr_hit_o(sfr_hit_o), .idle_i(idle_i), .power_down_i(power_down_i), .ext_int_n_i(ext_int_n_i),
        .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o),
        .device_reset_o(device_reset_o), .ale_disable_o(ale_disable_o), .armed_o(armed_o));
    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
            n_mismatch++;
        end
    endtask : check
    // bus cycles: writes may run back to back
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i);
        sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask : wr
    task automatic bus_idle();
        @(posedge clk_i);
        sfr <= '0;
    endtask : bus_idle
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk_i);
        sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        bus_idle();
        #1;
        check("hit", sfr_hit_o, 1'b1);
        check("rdata", sfr_rdata_o, exp);
    endtask : rd
    task automatic t_after_reset();
        check("armed", armed_o, 1'b0);
        check("oe_n", rst_pin_oe_n_o, 1'b1);
        rd(8'h8e, 8'h00);
        rd(8'ha6, 8'h00);
    endtask : t_after_reset
    // unimplemented aux bits must read back zero
    task automatic t_aux_bits();
        wr(8'h8e, 8'hff);
        rd(8'h8e, 8'h19);
        check("ale", ale_disable_o, 1'b1);
        wr(8'h8e, 8'h10);
        rd(8'h8e, 8'h10);
    endtask : t_aux_bits
    task automatic t_bad_seq();
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'h55);
        wr(8'ha6, 8'he1);
        bus_idle();
        repeat (2) @(posedge clk_i);
        check("armed", armed_o, 1'b0);
    endtask : t_bad_seq
    // counting in idle with a timer wake service, an outside pin reset, then a hard reset mid-run
    task automatic t_mid_reset();
        wr(8'h8e, 8'h08);
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'he1);
        bus_idle();
        idle_i <= 1'b1;
        repeat (24) @(posedge clk_i);
        idle_i <= 1'b0;
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'he1);
        bus_idle();
        idle_i <= 1'b1;
        rst_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        check("armed", armed_o, 1'b1);
        check("pin reset", device_reset_o, 1'b1);
        check("oe_n", rst_pin_oe_n_o, 1'b1);
        @(posedge clk_i);
        rst_pin_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        idle_i <= 1'b0;
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check("armed", armed_o, 1'b0);
        check("oe_n", rst_pin_oe_n_o, 1'b1);
        rd(8'h8e, 8'h00);
    endtask : t_mid_reset
    task automatic t_arm();
        wr(8'ha6, 8'h1e);
        wr(8'h8e, 8'h10);
        wr(8'ha6, 8'he1);
        bus_idle();
        repeat (2) @(posedge clk_i);
        check("armed", armed_o, 1'b1);
        wr(8'ha6, 8'h00);
        bus_idle();
        repeat (2) @(posedge clk_i);
        check("armed", armed_o, 1'b1);
    endtask : t_arm
    // service late, then 720 held cycles that must not count; each hold is 20 ticks, far outside the window
    task automatic t_overflow();
        repeat (240) @(posedge clk_i);
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'he1);
        bus_idle();
        idle_i <= 1'b1;
        repeat (240) @(posedge clk_i);
        idle_i <= 1'b0;
        power_down_i <= 1'b1;
        ext_int_n_i <= 1'b0;
        repeat (240) @(posedge clk_i);
        power_down_i <= 1'b0;
        repeat (240) @(posedge clk_i);
        ext_int_n_i <= 1'b1;
        // wake handler service; the counter is still held by the synced interrupt here
        wr(8'ha6, 8'h1e);
        wr(8'ha6, 8'he1);
        bus_idle();
        n = 0;
        while (!device_reset_o && n < 99000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check("ovf time", n > 98274 && n < 98334, 1'b1);
        n = 0;
        @(posedge clk_i);
        #1;
        while (rst_pin_o && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check("pulse", n, 32'h62);
        check("armed", armed_o, 1'b0);
        check("oe_n", rst_pin_oe_n_o, 1'b1);
    endtask : t_overflow
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // hang guard, run needs about 99.5k cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 100000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        reset_i = 1'b1;
        sfr = '0;
        idle_i = 1'b0;
        power_down_i = 1'b0;
        ext_int_n_i = 1'b1;
        rst_pin_i = 1'b0;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_after_reset();
        t_aux_bits();
        t_bad_seq();
        t_mid_reset();
        t_arm();
        t_overflow();
        complete_run();
    end
endmodule : tb_top
